// ### src/spi_queue_pkg.sv
// package: register map, field positions, reset values and types of the serial core
package spi_queue_pkg;

    // register byte addresses on the control bus
    localparam logic [7:0] ctrl0_addr   = 8'h00;  // serial_control_0
    localparam logic [7:0] ctrl1_addr   = 8'h04;  // serial_control_1
    localparam logic [7:0] ctrl2_addr   = 8'h08;  // serial_control_2
    localparam logic [7:0] status_addr  = 8'h0C;  // serial_status_reg
    localparam logic [7:0] rx_port_addr = 8'h10;  // rx_queue_port, read only
    localparam logic [7:0] tx_port_addr = 8'h14;  // tx_queue_port, write only
    localparam logic [7:0] clkdiv_addr  = 8'h18;  // master serial clock divider

    // serial_control_0 fields
    localparam int enable_pos        = 7;
    localparam int master_pos        = 1;
    localparam int lsb_first_pos     = 0;
    // serial_control_1 fields
    localparam int data_in_pol_pos   = 2;
    localparam int data_out_pol_pos  = 1;
    localparam int select_pol_pos    = 0;
    // serial_control_2 fields
    localparam int tx_req_pos        = 1;
    localparam int rx_en_pos         = 0;
    // serial_status_reg fields
    localparam int tx_write_err_pos  = 7;
    localparam int tx_empty_pos      = 5;
    localparam int buf_clear_pos     = 2;
    localparam int rx_full_pos       = 1;
    localparam int rx_read_err_pos   = 0;

    // reset values
    localparam logic [7:0] ctrl0_reset  = 8'h00;
    localparam logic [7:0] ctrl1_reset  = 8'h00;
    localparam logic [7:0] ctrl2_reset  = 8'h00;
    localparam logic [7:0] clkdiv_reset = 8'h03;

    // transfer length in bits
    localparam logic [3:0] bits_per_xfer = 4'h8;

    // axi response codes
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // transfer engine states, one-hot
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_shift = 3'b010,
        st_done  = 3'b100
    } xfer_state_t;

    // serial pins as seen by the core
    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic sel_out;
        logic sel_oe;
        logic sdo_out;
        logic sdo_oe;
    } pin_out_t;

endpackage

// ### src/spi_queue_core.sv
// serial peripheral core with two-byte queues, polarity control and axi-lite
// Functional notes
// - full duplex; master starts each exchange
// - separate two-byte transmit and receive queues
// - buffer clear bit empties both queues
// - disabling the module empties both queues
// - receive port read pops oldest byte
// - empty receive read returns zero, flags error
// - receive read error sticks until software clears
// - receive full flag when queue full
// - transmit port write pushes next slot
// - write to full transmit queue dropped, flagged
// - transmit empty flag when queue empty
// - occupancy counts never software readable
// - bit order: clear msb first, set lsb
// - polarity bits invert input, output, select
// - select polarity covers slave input, master output
// - disabled: select and clock outputs inactive
// - pin output: hold last bit, idle when disabled
// - slave input pin: tri-state when unselected/disabled/no tx
// - master: tri-state without tx enable, else hold
`timescale 1ns/1ps
`default_nettype none
module spi_queue_core #(
    parameter int depth = 2  // queue depth in bytes
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi-lite write address
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // axi-lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi-lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi-lite read address
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // axi-lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // serial pins
    input  wire logic                   sck_in,
    input  wire logic                   sel_in,
    input  wire logic                   sdi_in,
    input  wire logic                   sdo_pin_input,  // pin_direction_bit
    output var spi_queue_pkg::pin_out_t pins
);

    // whole state of the block
    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [7:0]  clkdiv;
        logic        rx_read_error_flag;
        logic        tx_write_error_flag;
        logic [7:0]  txq0, txq1;      // slot 0 is oldest
        logic [7:0]  rxq0, rxq1;
        logic [1:0]  tx_cnt, rx_cnt;  // internal occupancy only
        logic        aw_held, w_held;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        spi_queue_pkg::xfer_state_t st;
        logic [7:0]  sh_out, sh_in;
        logic [3:0]  bitcnt;
        logic [7:0]  divcnt;
        logic        sck_phase;       // master clock level, active sense
        logic        sdo_level;       // last bit driven, before polarity
        logic [1:0]  sck_s, sel_s, sdi_s;  // two-stage synchronisers
        logic [1:0]  sck_hist;        // after synchroniser, for edges
    } state_t;

    state_t s_reg, s_next;

    // next bit to shift out given bit order
    function automatic logic out_bit(input logic [7:0] b, input logic lsb_first_select);
        out_bit = lsb_first_select ? b[0] : b[7];
    endfunction

    // shift a byte one place in the chosen order, new bit entering
    function automatic logic [7:0] shift_in(input logic [7:0] b,
                                            input logic       nb,
                                            input logic       lsb_first_select);
        shift_in = lsb_first_select ? {nb, b[7:1]} : {b[6:0], nb};
    endfunction

    // decoded controls
    logic en, master, lsb_first_select, sdi_pol, sdo_pol, sel_pol, transmit_request_enable, rxen;
    assign en      = s_reg.ctrl0[spi_queue_pkg::enable_pos];
    assign master  = s_reg.ctrl0[spi_queue_pkg::master_pos];
    assign lsb_first_select    = s_reg.ctrl0[spi_queue_pkg::lsb_first_pos];
    assign sdi_pol = s_reg.ctrl1[spi_queue_pkg::data_in_pol_pos];
    assign sdo_pol = s_reg.ctrl1[spi_queue_pkg::data_out_pol_pos];
    assign sel_pol = s_reg.ctrl1[spi_queue_pkg::select_pol_pos];
    assign transmit_request_enable     = s_reg.ctrl2[spi_queue_pkg::tx_req_pos];
    assign rxen    = s_reg.ctrl2[spi_queue_pkg::rx_en_pos];

    // flag views of the queues
    logic rx_full_flag, tx_empty_flag, sel_active, sdi_val;
    assign rx_full_flag  = (s_reg.rx_cnt == 2'(depth));
    assign tx_empty_flag = (s_reg.tx_cnt == 2'h0);
    // select and data input sense, set polarity means active low
    assign sel_active = s_reg.sel_s[1] ^ sel_pol;
    assign sdi_val    = s_reg.sdi_s[1] ^ sdi_pol;

    // handshake outputs
    assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
    assign s_axi_wready  = !s_reg.w_held && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;

    // pin drive, registered state with polarity applied
    always_comb begin
        pins.sel_oe  = master;
        pins.sck_oe  = master;
        // disabled or idle: select inactive per its polarity
        pins.sel_out = ((s_reg.st != spi_queue_pkg::st_idle) && en)
                       ^ sel_pol;
        // clock idles low; disabled forces the idle level
        pins.sck_out = en & s_reg.sck_phase;
        // disabled returns data output to idle, otherwise hold last bit
        pins.sdo_out = (en & s_reg.sdo_level) ^ sdo_pol;
        if (!sdo_pin_input) begin
            pins.sdo_oe = 1'b1;
        end else if (master) begin
            pins.sdo_oe = transmit_request_enable;
        end else begin
            pins.sdo_oe = sel_active && en && transmit_request_enable;
        end
    end

    // all next-state logic
    always_comb begin
        logic        wr_go, rd_go, tx_push, rx_pop, clr;
        logic        tx_pop, rx_push, lead, trail;
        logic [7:0]  wb, rx_byte;
        wr_go   = 1'b0;
        rd_go   = 1'b0;
        tx_push = 1'b0;
        rx_pop  = 1'b0;
        clr     = 1'b0;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        lead    = 1'b0;
        trail   = 1'b0;
        wb      = s_reg.w_data[7:0];
        rx_byte = s_reg.sh_in;
        s_next  = s_reg;

        // synchronisers, first stage read only by the second
        s_next.sck_s    = {s_reg.sck_s[0], sck_in};
        s_next.sel_s    = {s_reg.sel_s[0], sel_in};
        s_next.sdi_s    = {s_reg.sdi_s[0], sdi_in};
        s_next.sck_hist = {s_reg.sck_hist[0], s_reg.sck_s[1]};

        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end

        // register writes, one cycle after both halves are held
        if (s_reg.aw_held && s_reg.w_held) begin
            wr_go          = s_reg.w_strb[0];
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = spi_queue_pkg::resp_okay;
            unique case (s_reg.aw_addr)
                spi_queue_pkg::ctrl0_addr:  if (wr_go) s_next.ctrl0 = wb;
                spi_queue_pkg::ctrl1_addr:  if (wr_go) s_next.ctrl1 = wb;
                spi_queue_pkg::ctrl2_addr:  if (wr_go) s_next.ctrl2 = wb;
                spi_queue_pkg::clkdiv_addr: if (wr_go) s_next.clkdiv = wb;
                spi_queue_pkg::status_addr: begin
                    // error flags written with zero are cleared
                    if (wr_go && !wb[spi_queue_pkg::rx_read_err_pos]) begin
                        s_next.rx_read_error_flag = 1'b0;
                    end
                    if (wr_go && !wb[spi_queue_pkg::tx_write_err_pos]) begin
                        s_next.tx_write_error_flag = 1'b0;
                    end
                    clr = wr_go && wb[spi_queue_pkg::buf_clear_pos];
                end
                spi_queue_pkg::tx_port_addr: tx_push = wr_go;
                default: s_next.bresp = spi_queue_pkg::resp_slverr;
            endcase
        end

        // register reads; occupancy counts have no address
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = spi_queue_pkg::resp_okay;
            s_next.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                spi_queue_pkg::ctrl0_addr:  s_next.rdata[7:0] = s_reg.ctrl0;
                spi_queue_pkg::ctrl1_addr:  s_next.rdata[7:0] = s_reg.ctrl1;
                spi_queue_pkg::ctrl2_addr:  s_next.rdata[7:0] = s_reg.ctrl2;
                spi_queue_pkg::clkdiv_addr: s_next.rdata[7:0] = s_reg.clkdiv;
                spi_queue_pkg::status_addr: begin
                    s_next.rdata[spi_queue_pkg::tx_write_err_pos] =
                        s_reg.tx_write_error_flag;
                    s_next.rdata[spi_queue_pkg::tx_empty_pos] = tx_empty_flag;
                    s_next.rdata[spi_queue_pkg::rx_full_pos]  = rx_full_flag;
                    s_next.rdata[spi_queue_pkg::rx_read_err_pos] =
                        s_reg.rx_read_error_flag;
                end
                spi_queue_pkg::rx_port_addr: begin
                    if (s_reg.rx_cnt != 2'h0) begin
                        s_next.rdata[7:0] = s_reg.rxq0;
                        rx_pop = 1'b1;
                    end else begin
                        // empty queue reads as zero and flags it
                        s_next.rx_read_error_flag = 1'b1;
                    end
                end
                default: s_next.rresp = spi_queue_pkg::resp_slverr;
            endcase
        end

        // transmit write error on full queue; set wins over clear
        if (tx_push && s_reg.tx_cnt == 2'(depth)) begin
            tx_push = 1'b0;
            s_next.tx_write_error_flag = 1'b1;
        end

        // serial clock edges: master makes its own, slave samples pin
        if (master) begin
            if (s_reg.st == spi_queue_pkg::st_shift) begin
                if (s_reg.divcnt == 8'h00) begin
                    s_next.divcnt    = s_reg.clkdiv;
                    s_next.sck_phase = !s_reg.sck_phase;
                    lead  = !s_reg.sck_phase;
                    trail = s_reg.sck_phase;
                end else begin
                    s_next.divcnt = s_reg.divcnt - 8'h01;
                end
            end
        end else begin
            lead  = s_reg.sck_hist == 2'b01;
            trail = s_reg.sck_hist == 2'b10;
        end

        // transfer engine, one byte each way per exchange
        unique case (s_reg.st)
            spi_queue_pkg::st_idle: begin
                // master starts on queued data; slave on select
                if (en && ((master && !tx_empty_flag) ||
                           (!master && sel_active))) begin
                    s_next.st     = spi_queue_pkg::st_shift;
                    s_next.bitcnt = 4'h0;
                    s_next.divcnt = s_reg.clkdiv;
                    s_next.sck_phase = 1'b0;
                    tx_pop = master && !tx_empty_flag;
                    s_next.sh_out = tx_empty_flag ? 8'h00 : s_reg.txq0;
                    s_next.sdo_level = out_bit(s_next.sh_out, lsb_first_select);
                end
            end
            spi_queue_pkg::st_shift: begin
                if (lead) begin
                    // sample on leading edge
                    s_next.sh_in  = shift_in(s_reg.sh_in, sdi_val, lsb_first_select);
                    s_next.bitcnt = s_reg.bitcnt + 4'h1;
                    // slave pops on its first bit
                    if (!master && s_reg.bitcnt == 4'h0) begin
                        tx_pop = !tx_empty_flag;
                    end
                end
                if (trail) begin
                    if (s_reg.bitcnt == spi_queue_pkg::bits_per_xfer) begin
                        s_next.st = spi_queue_pkg::st_done;
                    end else begin
                        // shift out on trailing edge, previous bit held
                        s_next.sh_out = shift_in(s_reg.sh_out, 1'b0, lsb_first_select);
                        s_next.sdo_level = out_bit(s_next.sh_out, lsb_first_select);
                    end
                end
                // slave released mid-byte: drop the partial byte
                if (!master && !sel_active) begin
                    s_next.st = spi_queue_pkg::st_idle;
                end
            end
            spi_queue_pkg::st_done: begin
                rx_push   = rxen;
                s_next.st = spi_queue_pkg::st_idle;
            end
            default: s_next.st = spi_queue_pkg::st_idle;
        endcase
        // a full receive queue keeps its data; new byte is lost unless a read pops in the same cycle
        if (rx_full_flag && !rx_pop) begin
            rx_push = 1'b0;
        end

        // transmit queue update
        if (tx_pop) begin
            s_next.txq0 = s_reg.txq1;
        end
        if (tx_push) begin
            if (s_reg.tx_cnt - 2'(tx_pop) == 2'h0) begin
                s_next.txq0 = wb;
            end else begin
                s_next.txq1 = wb;
            end
        end
        s_next.tx_cnt = s_reg.tx_cnt + 2'(tx_push) - 2'(tx_pop);

        // receive queue update
        if (rx_pop) begin
            s_next.rxq0 = s_reg.rxq1;
        end
        if (rx_push) begin
            if (s_reg.rx_cnt - 2'(rx_pop) == 2'h0) begin
                s_next.rxq0 = rx_byte;
            end else begin
                s_next.rxq1 = rx_byte;
            end
        end
        s_next.rx_cnt = s_reg.rx_cnt + 2'(rx_push) - 2'(rx_pop);

        // clear bit or disabled module empties both queues
        if (clr || !en) begin
            s_next.tx_cnt = 2'h0;
            s_next.rx_cnt = 2'h0;
        end
        // disabled: engine stops, data output returns to idle
        if (!en) begin
            s_next.st        = spi_queue_pkg::st_idle;
            s_next.sdo_level = 1'b0;
            s_next.sck_phase = 1'b0;
        end
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg        <= '0;
            s_reg.ctrl0  <= spi_queue_pkg::ctrl0_reset;
            s_reg.ctrl1  <= spi_queue_pkg::ctrl1_reset;
            s_reg.ctrl2  <= spi_queue_pkg::ctrl2_reset;
            s_reg.clkdiv <= spi_queue_pkg::clkdiv_reset;
            s_reg.st     <= spi_queue_pkg::st_idle;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

// ### tb/spi_queue_core_chk.sv
// checker: port-level properties of the serial queue core
`timescale 1ns/1ps
`default_nettype none
module spi_queue_core_chk (
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // bus handshakes
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    // serial pins
    input wire logic                    sdo_pin_input,
    input wire spi_queue_pkg::pin_out_t pins
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // serial clock rises since the select output last moved
    logic [3:0] rises_reg, rises_next;
    logic       sck_q_reg, sel_q_reg;
    always_comb begin
        rises_next = rises_reg;
        if (pins.sel_out != sel_q_reg) rises_next = 4'h0;
        else if (pins.sck_out && !sck_q_reg) rises_next = rises_reg + 4'h1;
    end
    // a rise in the same cycle as a select move is missed, so keep them apart
    always_ff @(posedge aclk) begin
        sck_q_reg <= pins.sck_out;
        sel_q_reg <= pins.sel_out;
        rises_reg <= aresetn ? rises_next : 4'h0;
    end
    property p_reset_idle;
        $rose(aresetn) |-> !pins.sck_out && !pins.sel_out
            && (pins.sdo_oe == !sdo_pin_input);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins busy at reset");
    property p_eight;
        pins.sck_oe && (pins.sel_out != sel_q_reg) |-> rises_reg inside {4'h0, 4'h8};
    endproperty
    a_eight: assert property (p_eight) else $error("frame length wrong");
    property p_sdo_drive;
        !sdo_pin_input [*6] |-> pins.sdo_oe;
    endproperty
    a_sdo_drive: assert property (p_sdo_drive) else $error("data out not driven");
    property p_oe_pair;
        pins.sck_oe == pins.sel_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("clock and select oe differ");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read answered twice");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write answered twice");
    property p_w_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
    // main scenarios reached
    c_frame: cover property (pins.sck_oe && pins.sel_out != sel_q_reg
        && rises_reg == 4'h8);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind spi_queue_core spi_queue_core_chk u_chk (.aclk, .aresetn,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sdo_pin_input, .pins);
`default_nettype wire

// ### tb/spi_far_model.sv
// far-side device: slave to a master core, master to a slave core
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
    // core side
    input wire logic       aclk,
    input wire logic       sck_o,
    input wire logic       sel_o,
    input wire logic       sdo_o,
    input wire logic       sel_pol,
    input wire logic [7:0] tx_byte,
    // lines towards the core
    output var logic       sdi,
    output var logic       sck_i,
    output var logic       sel_i,
    output var logic [7:0] rx_byte,
    output var logic [7:0] frames
);
    logic [7:0] sh;
    logic       mst, sel_on, act;
    int         n;
    assign sel_i = sel_on ? !sel_pol : sel_pol;
    assign act = (sel_o != sel_pol) && !mst;
    initial begin
        {sdi, sck_i, sel_on, mst, rx_byte, frames, sh} = 28'h0;
        n = 0;
    end
    // unselected, the data line carries garbage rather than a stale bit
    always @(posedge aclk) if (!act && !mst) sdi <= ~sdi;
    // reply loaded at select, alternating per frame; first bit out at once
    always @(posedge act) begin
        #1;
        n = 0;
        sh = tx_byte ^ {8{frames[0]}};
        sdi = sh[7];
    end
    always @(posedge sck_o) if (act) rx_byte = {rx_byte[6:0], sdo_o};
    always @(negedge sck_o) if (act) begin
        n = n + 1;
        sh = sh << 1;
        sdi = sh[7];
        if (n == 8) frames = frames + 8'h01;
    end
    // one byte as master, msb first, 200 ns serial clock, clock still outside
    task automatic frame(input logic [7:0] b, output logic [7:0] got);
        mst = 1'b1;
        #7;
        sel_on = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            sdi = b[i];
            #100;
            got[i] = sdo_o;
            sck_i = 1'b1;
            #100;
            sck_i = 1'b0;
        end
        #100;
        sel_on = 1'b0;
        mst = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench: bus stimulus, far-side model and queued result checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, sdo_pin, sel_pol;
    logic sck_in, sel_in, sdi_in;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr, araddr, m, b0, b1, b2, got, mrx, frames;
    logic [31:0] wdata, rdata;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    spi_queue_pkg::pin_out_t pins;
    integer seed, miscompares, cmp_count;
    spi_queue_core u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_in(sck_in),
        .sel_in(sel_in), .sdi_in(sdi_in), .sdo_pin_input(sdo_pin), .pins(pins));
    spi_far_model u_far (.aclk(aclk), .sck_o(pins.sck_out),
        .sel_o(pins.sel_out), .sel_pol(sel_pol),
        .sdo_o(pins.sdo_oe ? pins.sdo_out : !pins.sdo_out),
        .tx_byte(m), .sdi(sdi_in), .sck_i(sck_in), .sel_i(sel_in),
        .rx_byte(mrx), .frames(frames));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("FAIL at %0t: got %h expected %h", $time, g, e);
            miscompares++;
        end
    endtask
    // one bus access; the expected answer is queued for the monitor
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [1:0] r = 2'h0);
        if (w) bq.push_back(r);
        else rq.push_back({r, 24'h0, d});
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, 24'h0, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {{3{w}}, {2{!w}}};
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (bvalid || rvalid) break;
        end
        if (!(bvalid || rvalid)) begin
            miscompares++;
            conclude();
        end
        {bready, rready} <= 2'b00;
    endtask
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // answers are taken off the queues in the order they were asked for
    always @(posedge aclk) begin
        if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) cmp(bresp, bq.pop_front());
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, sdo_pin, sel_pol} = 50'h0;
        {seed, miscompares, cmp_count} = {32'h9D88, 64'h0};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        {m, b0, b1, b2} = $random(seed);
        bus(0, 8'h00, 8'h00);
        bus(0, 8'h18, 8'h03);
        bus(0, 8'h0C, 8'h20);
        bus(0, 8'h1C, 8'h00, 2'h2);
        bus(1, 8'h1C, 8'hFF, 2'h2);
        bus(0, 8'h10, 8'h00);
        bus(0, 8'h0C, 8'h21);
        bus(0, 8'h0C, 8'h21);
        bus(1, 8'h0C, 8'h00);
        $display("reset and empty read done");
        sdo_pin <= 1'b1;
        bus(1, 8'h04, 8'h01);
        sel_pol = 1'b1;
        bus(1, 8'h08, 8'h03);
        bus(1, 8'h00, 8'h80);
        cmp(pins.sdo_oe, 1'b0);
        bus(1, 8'h14, b0);
        bus(1, 8'h14, b1);
        bus(0, 8'h0C, 8'h00);
        bus(1, 8'h14, b2);
        bus(0, 8'h0C, 8'h80);
        u_far.frame(m, got);
        cmp(got, b0);
        u_far.frame(~m, got);
        cmp(got, b1);
        bus(0, 8'h0C, 8'hA2);
        bus(0, 8'h10, m);
        bus(0, 8'h10, ~m);
        bus(1, 8'h14, b2);
        bus(1, 8'h00, 8'h00);
        bus(0, 8'h0C, 8'hA0);
        bus(1, 8'h00, 8'h80);
        bus(1, 8'h14, b0);
        bus(1, 8'h0C, 8'h84);
        bus(0, 8'h0C, 8'hA0);
        bus(1, 8'h0C, 8'h00);
        bus(1, 8'h00, 8'h00);
        $display("slave and queue tests done");
        sdo_pin <= 1'b0;
        bus(1, 8'h04, 8'h06);
        sel_pol = 1'b0;
        bus(1, 8'h18, 8'h02);
        bus(1, 8'h00, 8'h83);
        bus(1, 8'h14, b2);
        for (int i = 0; i < 4000 && frames !== 8'h01; i++) @(posedge aclk);
        if (frames !== 8'h01) begin
            miscompares++;
            conclude();
        end
        cmp(mrx, rev(~b2));
        bus(0, 8'h10, rev(~m));
        cmp(pins.sdo_out, !b2[7]);
        bus(1, 8'h00, 8'h00);
        cmp({pins.sel_out, pins.sck_out}, 2'b00);
        cmp(pins.sdo_out, 1'b1);
        bus(1, 8'h04, 8'h01);
        cmp(pins.sel_out, 1'b1);
        sel_pol = 1'b1;
        sdo_pin <= 1'b1;
        bus(1, 8'h08, 8'h01);
        bus(1, 8'h00, 8'h82);
        cmp(pins.sdo_oe, 1'b0);
        $display("master and polarity tests done");
        conclude();
    end
endmodule
`default_nettype wire
